// *** core/lsba_bit_unit.sv ***
// Single-bit manipulation unit: selects, modifies and tests one bit of a byte.
// Assumes a purely combinational use by the datapath core.
`timescale 1ns/100ps
module lsba_bit_unit
    import lsba_pkg::*;
(
    // Operand and selection
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_index,
    input wire lsba_op_t op,
    input wire logic carry_in,
    // Results
    output logic [7:0] result,
    output logic carry_out,
    output logic zero_out,
    output logic writes_operand,
    output logic writes_carry,
    output logic writes_zero
);

    logic [7:0] mask;
    logic sel;

    always_comb begin
        mask = LSBA_ONE_BIT << bit_index;
        sel = operand[bit_index];
        result = operand;
        carry_out = carry_in;
        zero_out = ~sel;
        writes_operand = 1'b0;
        writes_carry = 1'b0;
        writes_zero = 1'b0;
        unique case (op)
            OP_BIT_SET: begin
                result = operand | mask;
                writes_operand = 1'b1;
            end
            OP_BIT_CLEAR: begin
                result = operand & ~mask;
                writes_operand = 1'b1;
            end
            OP_BIT_INVERT: begin
                result = operand ^ mask;
                writes_operand = 1'b1;
            end
            OP_BIT_TEST: writes_zero = 1'b1;
            OP_BIT_AND_CARRY: begin
                carry_out = carry_in & sel;
                writes_carry = 1'b1;
            end
            OP_INV_BIT_AND_CARRY: begin
                carry_out = carry_in & ~sel;
                writes_carry = 1'b1;
            end
            OP_BIT_OR_CARRY: begin
                carry_out = carry_in | sel;
                writes_carry = 1'b1;
            end
            OP_INV_BIT_OR_CARRY: begin
                carry_out = carry_in | ~sel;
                writes_carry = 1'b1;
            end
            OP_BIT_XOR_CARRY: begin
                carry_out = carry_in ^ sel;
                writes_carry = 1'b1;
            end
            OP_INV_BIT_XOR_CARRY: begin
                carry_out = carry_in ^ ~sel;
                writes_carry = 1'b1;
            end
            OP_LOAD_BIT_TO_CARRY: begin
                carry_out = sel;
                writes_carry = 1'b1;
            end
            OP_LOAD_INV_BIT_TO_CARRY: begin
                carry_out = ~sel;
                writes_carry = 1'b1;
            end
            OP_STORE_CARRY_TO_BIT: begin
                result = (operand & ~mask) | (carry_in ? mask : LSBA_ZERO_BYTE);
                writes_operand = 1'b1;
            end
            OP_STORE_INV_CARRY_TO_BIT: begin
                result = (operand & ~mask) | (carry_in ? LSBA_ZERO_BYTE : mask);
                writes_operand = 1'b1;
            end
            default: begin
                result = operand;
            end
        endcase
    end

endmodule

// *** core/lsba_core.sv ***
// Logic, shift/rotate and bit-manipulation execution datapath, byte wide.
// Assumes decode presents one operation per start pulse and a memory port
// that answers a read with mem_rvalid; carry and zero flags are kept here.
// Operation
// - AND destination register with source register or immediate, result to destination.
// - OR destination register with source register or immediate, result to destination.
// - XOR destination register with source register or immediate, result to destination.
// - Replace destination register with its one's complement.
// - Arithmetic shift left and right of a register, written back.
// - Logical shift left and right of a register, written back.
// - Rotate left and right of a register without carry, written back.
// - Rotate left and right through carry as nine-bit loop, written back.
// - Bit set forces the selected bit to one, others unchanged.
// - Bit clear forces the selected bit to zero, others unchanged.
// - Bit invert toggles the selected bit, others unchanged.
// - Bit test loads zero flag with inverse of selected bit.
// - Set, clear, invert, test index from 3-bit immediate or register low bits.
// - Carry becomes carry AND selected bit.
// - Carry becomes carry AND inverse of selected bit.
// - Carry becomes carry OR selected bit.
// - Carry becomes carry OR inverse of selected bit.
// - Carry becomes carry XOR selected bit.
// - Carry becomes carry XOR inverse of selected bit.
// - Bit load copies selected bit, or its inverse, into carry.
// - Bit store writes carry, or its inverse, into selected bit.
// - All carry, load and store operations, plain or inverted, take index from immediate only.
`timescale 1ns/100ps
module lsba_core
    import lsba_pkg::*;
#(
    parameter int DATA_W = LSBA_DATA_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request from decode
    input wire logic start,
    input wire lsba_op_t op,
    input wire logic [7:0] dest_value,
    input wire logic [7:0] source_register,
    input wire logic [7:0] immediate,
    input wire logic use_immediate,
    input wire logic [2:0] bit_index_imm,
    input wire logic index_from_register,
    input wire logic target_memory,
    // Flag load from the rest of the core
    input wire logic flags_load,
    input wire logic carry_load_value,
    input wire logic zero_load_value,
    // Memory byte port
    output logic mem_read,
    output logic mem_write,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    // Results
    output logic busy,
    output logic done,
    output logic reg_write,
    output logic [7:0] result,
    output logic carry_flag,
    output logic zero_flag
);

    // All state of the core, registered as one word
    typedef struct packed {
        lsba_state_t state;
        lsba_op_t op;
        logic [2:0] index;
        logic [7:0] result;
        logic reg_write;
        logic mem_read;
        logic mem_write;
        logic done;
        logic carry;
        logic zero;
    } lsba_regs_t;

    // Reset value of all state
    localparam lsba_regs_t REGS_AT_RESET = '{
        state: ST_IDLE,
        op: OP_AND,
        index: 3'h0,
        result: LSBA_ZERO_BYTE,
        reg_write: 1'b0,
        mem_read: 1'b0,
        mem_write: 1'b0,
        done: 1'b0,
        carry: 1'b0,
        zero: 1'b0
    };

    lsba_regs_t r_q;
    lsba_regs_t r_d;

    // Operand selects and bit unit results
    logic [7:0] operand_b;
    logic [7:0] bit_operand;
    logic [2:0] bit_index;
    logic [7:0] bit_result;
    logic bit_carry;
    logic bit_zero;
    logic bit_wr_op;
    logic bit_wr_c;
    logic bit_wr_z;
    lsba_op_t bit_op;
    logic [9:0] reg_eval;
    logic mem_phase;
    logic index_by_reg;

    // Register index only allowed for set, clear, invert and test
    function automatic logic index_reg_allowed(input lsba_op_t o);
        return (o == OP_BIT_SET) || (o == OP_BIT_CLEAR) ||
               (o == OP_BIT_INVERT) || (o == OP_BIT_TEST);
    endfunction

    function automatic logic is_bit_op(input lsba_op_t o);
        return o >= OP_BIT_SET;
    endfunction

    // Register logic, shift and rotate result: {carry written, carry, byte}
    function automatic logic [9:0] reg_op_eval(input lsba_op_t o, input logic [7:0] d,
            input logic [7:0] b, input logic c);
        logic [7:0] res;
        logic cy;
        logic wc;
        res = d;
        cy = c;
        wc = 1'b0;
        unique case (o)
            OP_AND: res = d & b;
            OP_OR: res = d | b;
            OP_XOR: res = d ^ b;
            OP_NOT: res = ~d;
            OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: begin
                res = {d[6:0], 1'b0};
                cy = d[LSBA_MSB];
                wc = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT: begin
                res = {d[LSBA_MSB], d[7:1]};
                cy = d[0];
                wc = 1'b1;
            end
            OP_LOGIC_SHIFT_RIGHT: begin
                res = {1'b0, d[7:1]};
                cy = d[0];
                wc = 1'b1;
            end
            OP_ROTATE_LEFT: begin
                res = {d[6:0], d[LSBA_MSB]};
                cy = d[LSBA_MSB];
                wc = 1'b1;
            end
            OP_ROTATE_RIGHT: begin
                res = {d[0], d[7:1]};
                cy = d[0];
                wc = 1'b1;
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
                res = {d[6:0], c};
                cy = d[LSBA_MSB];
                wc = 1'b1;
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                res = {c, d[7:1]};
                cy = d[0];
                wc = 1'b1;
            end
            default: res = d;
        endcase
        return {wc, cy, res};
    endfunction

    // Flag updates that the bit unit asks for
    function automatic lsba_regs_t take_bit_flags(input lsba_regs_t r, input logic wc,
            input logic c, input logic wz, input logic z);
        lsba_regs_t n;
        n = r;
        if (wc) begin
            n.carry = c;
        end
        if (wz) begin
            n.zero = z;
        end
        return n;
    endfunction

    // Operand and index selection
    always_comb begin
        mem_phase = (r_q.state == ST_MEM_READ);
        index_by_reg = index_from_register && index_reg_allowed(op);
        operand_b = use_immediate ? immediate : source_register;
        bit_operand = mem_phase ? mem_rdata : dest_value;
        bit_op = mem_phase ? r_q.op : op;
        if (mem_phase) begin
            bit_index = r_q.index;
        end else if (index_by_reg) begin
            bit_index = source_register[2:0];
        end else begin
            bit_index = bit_index_imm;
        end
        // Rotate through carry takes the flag as it stood before this operation
        reg_eval = reg_op_eval(op, dest_value, operand_b, r_q.carry);
    end

    // Bit-manipulation unit
    lsba_bit_unit u_bit (
        .operand(bit_operand),
        .bit_index(bit_index),
        .op(bit_op),
        .carry_in(r_q.carry),
        .result(bit_result),
        .carry_out(bit_carry),
        .zero_out(bit_zero),
        .writes_operand(bit_wr_op),
        .writes_carry(bit_wr_c),
        .writes_zero(bit_wr_z)
    );

    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.reg_write = 1'b0;
        r_d.mem_read = 1'b0;
        r_d.mem_write = 1'b0;
        if (flags_load) begin
            r_d.carry = carry_load_value;
            r_d.zero = zero_load_value;
        end
        unique case (r_q.state)
            ST_IDLE: begin
                if (start) begin
                    r_d.op = op;
                    r_d.index = bit_index;
                    if (is_bit_op(op) && target_memory) begin
                        r_d.mem_read = 1'b1;
                        r_d.state = ST_MEM_READ;
                    end else if (is_bit_op(op)) begin
                        r_d = take_bit_flags(r_d, bit_wr_c, bit_carry, bit_wr_z, bit_zero);
                        r_d.done = 1'b1;
                        r_d.reg_write = bit_wr_op;
                        r_d.result = bit_result;
                    end else begin
                        r_d.done = 1'b1;
                        r_d.reg_write = 1'b1;
                        r_d.result = reg_eval[7:0];
                        if (reg_eval[9]) begin
                            r_d.carry = reg_eval[8];
                        end
                    end
                end
            end
            ST_MEM_READ: begin
                if (mem_rvalid) begin
                    r_d = take_bit_flags(r_d, bit_wr_c, bit_carry, bit_wr_z, bit_zero);
                    r_d.result = bit_result;
                    if (bit_wr_op) begin
                        r_d.mem_write = 1'b1;
                        r_d.state = ST_MEM_WRITE;
                    end else begin
                        r_d.done = 1'b1;
                        r_d.state = ST_IDLE;
                    end
                end
            end
            ST_MEM_WRITE: begin
                r_d.done = 1'b1;
                r_d.state = ST_IDLE;
            end
            default: r_d.state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_q <= REGS_AT_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // Memory port
    assign mem_read = r_q.mem_read;
    assign mem_write = r_q.mem_write;
    assign mem_wdata = r_q.result;

    // Status
    assign busy = (r_q.state != ST_IDLE);
    assign done = r_q.done;
    assign reg_write = r_q.reg_write;

    // Result and flags
    assign result = r_q.result;
    assign carry_flag = r_q.carry;
    assign zero_flag = r_q.zero;

endmodule

// *** include/lsba_pkg.sv ***
// Package for the logic, shift and bit-manipulation datapath.
// Assumes one 200 MHz clock and decode that supplies an operation code.
package lsba_pkg;

    localparam int LSBA_DATA_W = 8;
    localparam int LSBA_IDX_W = 3;
    localparam int LSBA_OP_W = 5;
    localparam logic [7:0] LSBA_ZERO_BYTE = 8'h00;
    localparam logic [7:0] LSBA_ONE_BIT = 8'h01;
    localparam int LSBA_MSB = 7;

    // Operation codes
    typedef enum logic [4:0] {
        OP_AND = 5'h00,
        OP_OR = 5'h01,
        OP_XOR = 5'h02,
        OP_NOT = 5'h03,
        OP_ARITH_SHIFT_LEFT = 5'h04,
        OP_ARITH_SHIFT_RIGHT = 5'h05,
        OP_LOGIC_SHIFT_LEFT = 5'h06,
        OP_LOGIC_SHIFT_RIGHT = 5'h07,
        OP_ROTATE_LEFT = 5'h08,
        OP_ROTATE_RIGHT = 5'h09,
        OP_ROTATE_LEFT_VIA_CARRY = 5'h0A,
        OP_ROTATE_RIGHT_VIA_CARRY = 5'h0B,
        OP_BIT_SET = 5'h0C,
        OP_BIT_CLEAR = 5'h0D,
        OP_BIT_INVERT = 5'h0E,
        OP_BIT_TEST = 5'h0F,
        OP_BIT_AND_CARRY = 5'h10,
        OP_INV_BIT_AND_CARRY = 5'h11,
        OP_BIT_OR_CARRY = 5'h12,
        OP_INV_BIT_OR_CARRY = 5'h13,
        OP_BIT_XOR_CARRY = 5'h14,
        OP_INV_BIT_XOR_CARRY = 5'h15,
        OP_LOAD_BIT_TO_CARRY = 5'h16,
        OP_LOAD_INV_BIT_TO_CARRY = 5'h17,
        OP_STORE_CARRY_TO_BIT = 5'h18,
        OP_STORE_INV_CARRY_TO_BIT = 5'h19
    } lsba_op_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MEM_READ = 3'b010,
        ST_MEM_WRITE = 3'b100
    } lsba_state_t;

endpackage

// *** sim/lsba_core_monitor.sv ***
// Assertions on the ports of the datapath core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module lsba_core_monitor
    import lsba_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request
    input wire logic start,
    input wire lsba_op_t op,
    input wire logic [7:0] dest_value,
    input wire logic [7:0] source_register,
    input wire logic [7:0] immediate,
    input wire logic use_immediate,
    input wire logic [2:0] bit_index_imm,
    input wire logic index_from_register,
    input wire logic target_memory,
    // Flags and memory
    input wire logic flags_load,
    input wire logic carry_load_value,
    input wire logic zero_load_value,
    input wire logic mem_read,
    input wire logic mem_write,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    // Results
    input wire logic busy,
    input wire logic done,
    input wire logic reg_write,
    input wire logic [7:0] result,
    input wire logic carry_flag,
    input wire logic zero_flag
);
    logic go;
    logic [7:0] src;
    logic [2:0] idx;
    assign go = start && !busy && !target_memory;
    assign src = use_immediate ? immediate : source_register;
    assign idx = index_from_register ? source_register[2:0] : bit_index_imm;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_AND: assert property (go && op == OP_AND
        |=> done && result == ($past(dest_value) & $past(src))) else $error("and wrong");
    AST_OR: assert property (go && op == OP_OR
        |=> result == ($past(dest_value) | $past(src))) else $error("or wrong");
    AST_XOR: assert property (go && op == OP_XOR
        |=> result == ($past(dest_value) ^ $past(src))) else $error("xor wrong");
    AST_NOT: assert property (go && op == OP_NOT
        |=> reg_write && result == ~$past(dest_value)) else $error("not wrong");
    AST_SET: assert property (go && op == OP_BIT_SET
        |=> result == ($past(dest_value) | (LSBA_ONE_BIT << $past(idx))))
        else $error("bit set wrong");
    AST_TEST: assert property (go && op == OP_BIT_TEST
        |=> zero_flag == !$past(dest_value[idx]) && !reg_write) else $error("test wrong");
    AST_LOAD: assert property (go && op == OP_LOAD_BIT_TO_CARRY
        |=> carry_flag == $past(dest_value[bit_index_imm])) else $error("load wrong");
    AST_MEM_READ: assert property (start && !busy && target_memory && op >= OP_BIT_SET
        |=> mem_read && busy) else $error("no memory read");
    AST_MEM_END: assert property (mem_write
        |=> done && !busy && !mem_write) else $error("memory write not closed");
    cover property (mem_write);
    cover property (go && op == OP_BIT_TEST);
    cover property (go && op == OP_ROTATE_RIGHT_VIA_CARRY);
endmodule

bind lsba_core lsba_core_monitor u_mon (
    .clk(clk), .nrst(nrst), .start(start), .op(op), .dest_value(dest_value),
    .source_register(source_register), .immediate(immediate),
    .use_immediate(use_immediate), .bit_index_imm(bit_index_imm),
    .index_from_register(index_from_register), .target_memory(target_memory),
    .flags_load(flags_load), .carry_load_value(carry_load_value),
    .zero_load_value(zero_load_value), .mem_read(mem_read), .mem_write(mem_write),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .busy(busy), .done(done), .reg_write(reg_write), .result(result),
    .carry_flag(carry_flag), .zero_flag(zero_flag)
);

// *** sim/tb_top.sv ***
// Self-checking bench for the datapath core.
// Drives decode, flag and memory ports itself; one 200 MHz clock.
`timescale 1ns/100ps
module tb_top;
    import lsba_pkg::*;
    logic clk = 0, nrst = 0, start = 0, use_immediate = 0, index_from_register = 0;
    logic target_memory = 0, flags_load = 0, carry_load_value = 0, zero_load_value = 0;
    logic mem_rvalid = 0, mem_read, mem_write, busy, done, reg_write, carry_flag, zero_flag;
    lsba_op_t op = OP_AND;
    logic [7:0] dest_value = 8'h00, source_register = 8'h00, immediate = 8'h00;
    logic [7:0] mem_rdata = 8'hA5, mem_wdata, result;
    logic [2:0] bit_index_imm = 3'h0;
    int fails = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    lsba_core dut (
        .clk(clk), .nrst(nrst), .start(start), .op(op), .dest_value(dest_value),
        .source_register(source_register), .immediate(immediate),
        .use_immediate(use_immediate), .bit_index_imm(bit_index_imm),
        .index_from_register(index_from_register), .target_memory(target_memory),
        .flags_load(flags_load), .carry_load_value(carry_load_value),
        .zero_load_value(zero_load_value), .mem_read(mem_read), .mem_write(mem_write),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .busy(busy), .done(done), .reg_write(reg_write), .result(result),
        .carry_flag(carry_flag), .zero_flag(zero_flag)
    );

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask

    // Loads carry, issues one register op, checks done one cycle later
    task automatic do_op(lsba_op_t o, logic [7:0] d, s, imm, logic ui, logic [2:0] ix,
            logic fr, logic c);
        @(posedge clk);
        flags_load <= 1'b1;
        carry_load_value <= c;
        @(posedge clk);
        flags_load <= 1'b0;
        start <= 1'b1;
        op <= o;
        dest_value <= d;
        source_register <= s;
        immediate <= imm;
        use_immediate <= ui;
        bit_index_imm <= ix;
        index_from_register <= fr;
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk("done", 8'h01, {7'h00, done});
    endtask

    task automatic test_logic;
        lsba_op_t ops[7] = '{OP_AND, OP_AND, OP_OR, OP_OR, OP_XOR, OP_XOR, OP_NOT};
        logic [7:0] exp[7] = '{8'h42, 8'h03, 8'hDB, 8'hCF, 8'h99, 8'hCC, 8'h3C};
        for (int i = 0; i < 7; i++) begin
            do_op(ops[i], 8'hC3, 8'h5A, 8'h0F, i[0], 3'h0, 1'b0, 1'b0);
            chk("logic result", exp[i], result);
            chk("logic write", 8'h01, {7'h00, reg_write});
        end
        $display("test_logic ended");
    endtask

    task automatic test_shift;
        logic [7:0] exp[8] = '{8'h2A, 8'hCA, 8'h2A, 8'h4A, 8'h2B, 8'hCA, 8'h2B, 8'hCA};
        for (int i = 0; i < 8; i++) begin
            do_op(lsba_op_t'(5'h04 + 5'(i)), 8'h95, 8'h00, 8'h00, 1'b0, 3'h0, 1'b0, i >= 6);
            chk("shift result", exp[i], result);
            chk("shift carry", 8'h01, {7'h00, carry_flag});
        end
        $display("test_shift ended");
    endtask

    task automatic test_bit_reg;
        do_op(OP_BIT_SET, 8'hA5, 8'hF9, 8'h00, 1'b0, 3'h6, 1'b1, 1'b0);
        chk("set", 8'hA7, result);
        do_op(OP_BIT_CLEAR, 8'hA5, 8'h00, 8'h00, 1'b0, 3'h7, 1'b0, 1'b0);
        chk("clear", 8'h25, result);
        do_op(OP_BIT_INVERT, 8'hA5, 8'h02, 8'h00, 1'b0, 3'h0, 1'b1, 1'b0);
        chk("invert", 8'hA1, result);
        do_op(OP_STORE_CARRY_TO_BIT, 8'hA5, 8'h04, 8'h00, 1'b0, 3'h1, 1'b1, 1'b1);
        chk("store", 8'hA7, result);
        do_op(OP_STORE_INV_CARRY_TO_BIT, 8'hA5, 8'h01, 8'h00, 1'b0, 3'h0, 1'b1, 1'b1);
        chk("store inv", 8'hA4, result);
        chk("store write", 8'h01, {7'h00, reg_write});
        $display("test_bit_reg ended");
    endtask

    task automatic test_bit_carry;
        logic [7:0] cin = 8'h73;
        logic [7:0] exp = 8'h9A;
        for (int i = 0; i < 8; i++) begin
            do_op(lsba_op_t'(5'h10 + 5'(i)), 8'hA5, 8'h00, 8'h00, 1'b0, 3'h1, 1'b1, cin[i]);
            chk("carry", {7'h00, exp[i]}, {7'h00, carry_flag});
            chk("carry no write", 8'h00, {7'h00, reg_write});
        end
        do_op(OP_BIT_TEST, 8'hA5, 8'h00, 8'h00, 1'b0, 3'h1, 1'b0, 1'b0);
        chk("test imm", 8'h01, {7'h00, zero_flag});
        do_op(OP_BIT_TEST, 8'hA5, 8'h00, 8'h00, 1'b0, 3'h1, 1'b1, 1'b0);
        chk("test reg", 8'h00, {6'h00, zero_flag, reg_write});
        $display("test_bit_carry ended");
    endtask

    task automatic test_memory;
        @(posedge clk);
        start <= 1'b1;
        op <= OP_BIT_INVERT;
        target_memory <= 1'b1;
        index_from_register <= 1'b0;
        bit_index_imm <= 3'h3;
        @(posedge clk);
        op <= OP_NOT;
        #1;
        chk("mem read", 8'h03, {6'h00, mem_read, busy});
        @(posedge clk);
        start <= 1'b0;
        mem_rdata <= 8'h5A;
        mem_rvalid <= 1'b1;
        @(posedge clk);
        mem_rvalid <= 1'b0;
        mem_rdata <= 8'hA5;
        #1;
        chk("mem write", 8'h02, {6'h00, mem_write, done});
        chk("mem data", 8'h52, mem_wdata);
        @(posedge clk);
        target_memory <= 1'b0;
        #1;
        chk("mem done", 8'h02, {6'h00, done, busy});
        @(posedge clk);
        flags_load <= 1'b1;
        carry_load_value <= 1'b0;
        start <= 1'b1;
        op <= OP_LOAD_BIT_TO_CARRY;
        target_memory <= 1'b1;
        bit_index_imm <= 3'h6;
        @(posedge clk);
        flags_load <= 1'b0;
        start <= 1'b0;
        mem_rdata <= 8'h40;
        mem_rvalid <= 1'b1;
        @(posedge clk);
        mem_rvalid <= 1'b0;
        target_memory <= 1'b0;
        #1;
        chk("mem load", 8'h05, {4'h0, mem_write, done, busy, carry_flag});
        $display("test_memory ended");
    endtask

    initial begin
        #20000;
        fails++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        test_logic();
        test_shift();
        test_bit_reg();
        test_bit_carry();
        test_memory();
        give_verdict();
    end
endmodule
